/* hdl/adc_format_regs.sv */
// configuration register bank: number format, time stamp, data rate, I offset
// Overview of operation
// - format bit selects offset binary or twos complement
// - time stamp capture only when enable set
// - rate bit zero dual, one single rate
// - sign bit chooses positive or negative offset
// - magnitude straight binary, 0 to 45 mV
// - magnitude resets zero; 800h is midscale
// - interleave bit selects dual or interleaved mode
`timescale 1ns/10ps
`include "adc_format_params.svh"
module adc_format_regs (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [`ADDR_W-1:0] reg_addr,
   input wire logic [`DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [`DATA_W-1:0] reg_rdata,
   input wire logic [`SAMPLE_W-1:0] sample_in,
   input wire logic timestamp_in,
   output logic [`SAMPLE_W-1:0] sample_out,
   output logic timestamp_out,
   output logic single_rate_select,
   output logic interleave_enable,
   output adc_format_pkg::chan_mode_e chan_mode,
   output logic reserved_misuse
);
   adc_format_pkg::reg_word_t primary_configuration;
   adc_format_pkg::reg_word_t reserved_fixed_pattern;
   adc_format_pkg::reg_word_t i_channel_offset_adjust;

   // address decode
   wire logic hit_cfg = reg_addr == `REG_PRIMARY_CFG;
   wire logic hit_rsvd = reg_addr == `REG_RESERVED_FIXED;
   wire logic hit_off = reg_addr == `REG_I_OFFSET;
   wire logic wr_cfg = reg_write && hit_cfg;
   wire logic wr_rsvd = reg_write && hit_rsvd;
   wire logic wr_off = reg_write && hit_off;

   // field views
   wire logic twos_comp_select = primary_configuration[`BIT_TWOS_COMP];
   wire logic timestamp_enable_bit = primary_configuration[`BIT_TIMESTAMP];
   wire logic offset_sign = i_channel_offset_adjust[`BIT_OFFSET_SIGN];
   wire logic [`SAMPLE_W-1:0] offset_magnitude =
      i_channel_offset_adjust[`OFFSET_MAG_MSB:0];
   assign single_rate_select = primary_configuration[`BIT_SINGLE_RATE];
   assign interleave_enable = primary_configuration[`BIT_INTERLEAVE];
   assign chan_mode = interleave_enable ? adc_format_pkg::MODE_INTERLEAVED
      : adc_format_pkg::MODE_DUAL;

   // read mux; unmapped addresses answer zero
   wire logic [`DATA_W-1:0] next_rdata = hit_cfg ? primary_configuration :
      hit_rsvd ? reserved_fixed_pattern :
      hit_off ? i_channel_offset_adjust : '0;

   // register writes; reserved bits of the config word hold their defaults
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         primary_configuration <= `PRIMARY_CFG_RESET;
         reserved_fixed_pattern <= `RESERVED_FIXED_RESET;
         i_channel_offset_adjust <= `I_OFFSET_RESET;
      end else begin
         if (wr_cfg) begin
            primary_configuration <= (reg_wdata & `PRIMARY_CFG_WMASK)
               | (`PRIMARY_CFG_RESET & ~`PRIMARY_CFG_WMASK);
         end
         if (wr_rsvd) begin
            reserved_fixed_pattern <= reg_wdata;
         end
         if (wr_off) begin
            i_channel_offset_adjust <= reg_wdata;
         end
      end
   end

   // read data stands only in the cycle after the read strobe
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_read ? next_rdata : '0;
      end
   end

   // flag software misuse of reserved contents rather than obey it silently
   wire logic bad_write = (wr_rsvd && reg_wdata != `RESERVED_FIXED_RESET) ||
      (wr_off && (reg_wdata & `I_OFFSET_RSVD_MASK) != '0);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reserved_misuse <= 1'b0;
      end else begin
         reserved_misuse <= reserved_misuse | bad_write;
      end
   end

   // time stamp capture gated by its enable
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         timestamp_out <= 1'b0;
      end else begin
         timestamp_out <= timestamp_enable_bit & timestamp_in;
      end
   end

   offset_apply u_offset_apply (
      .mclk(mclk),
      .reset_n(reset_n),
      .sample_in(sample_in),
      .offset_sign(offset_sign),
      .offset_magnitude(offset_magnitude),
      .twos_comp_select(twos_comp_select),
      .sample_out(sample_out)
   );

   // read data stands only in the cycle after its strobe, zero otherwise
   read_timing_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !$past(reg_read) |-> reg_rdata == '0)
      else $error("read data outside its cycle");

   // a write is followed by the cycle in which the new word stands
   sequence cfg_write_s;
      wr_cfg ##1 1'b1;
   endsequence
   sequence rsvd_write_s;
      wr_rsvd ##1 1'b1;
   endsequence
   sequence off_write_s;
      wr_off ##1 1'b1;
   endsequence

   // stored words and the flag are back at their defaults once reset lets go
   offset_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
      $rose(reset_n) |-> i_channel_offset_adjust == '0)
      else $error("offset not zero");
   cfg_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
      $rose(reset_n) |-> primary_configuration == `PRIMARY_CFG_RESET)
      else $error("config word not at default");
   rsvd_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
      $rose(reset_n) |-> reserved_fixed_pattern == `RESERVED_FIXED_RESET)
      else $error("reserved word not at default");
   misuse_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
      $rose(reset_n) |-> !reserved_misuse)
      else $error("misuse flag survived reset");

   // offset binary with no offset passes the sample through untouched
   binary_pass_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !twos_comp_select && !offset_sign && offset_magnitude == '0
      |=> sample_out == $past(sample_in))
      else $error("offset binary sample altered");

   // two's complement is the offset binary code with its top bit flipped
   format_flip_a: assert property (@(posedge mclk) disable iff (!reset_n)
      twos_comp_select && !offset_sign && offset_magnitude == '0
      |=> sample_out == ($past(sample_in) ^ `SAMPLE_MID))
      else $error("format not applied");
   twos_out_a: assert property (@(posedge mclk) disable iff (!reset_n)
      twos_comp_select && offset_sign && (sample_in >= offset_magnitude)
      |=> sample_out == (($past(sample_in) - $past(offset_magnitude)) ^ `SAMPLE_MID))
      else $error("twos complement offset sample wrong");

   // in-range offsets add or subtract the magnitude exactly
   positive_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !offset_sign && !twos_comp_select && ({1'b0, sample_in} + {1'b0, offset_magnitude}
      <= `SAMPLE_MAX) |=> sample_out == $past(sample_in) + $past(offset_magnitude))
      else $error("positive offset wrong");
   negative_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
      offset_sign && !twos_comp_select && (sample_in >= offset_magnitude)
      |=> sample_out == $past(sample_in) - $past(offset_magnitude))
      else $error("negative offset wrong");

   // out-of-range results stop at the code range ends; wrapping would flip polarity
   pos_clip_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !offset_sign && !twos_comp_select && ({1'b0, sample_in} + {1'b0, offset_magnitude}
      > `SAMPLE_MAX) |=> &sample_out)
      else $error("positive offset wrapped");
   neg_clip_a: assert property (@(posedge mclk) disable iff (!reset_n)
      offset_sign && !twos_comp_select && (offset_magnitude > sample_in)
      |=> sample_out == '0)
      else $error("negative offset wrapped");

   // config fields follow the word written one cycle earlier
   format_store_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cfg_write_s |-> twos_comp_select == $past(reg_wdata[`BIT_TWOS_COMP]))
      else $error("format bit not stored");
   stamp_store_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cfg_write_s |-> timestamp_enable_bit == $past(reg_wdata[`BIT_TIMESTAMP]))
      else $error("stamp enable not stored");
   rate_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_cfg |=> single_rate_select == $past(reg_wdata[`BIT_SINGLE_RATE]))
      else $error("rate bit not stored");
   mode_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_cfg ##1 1'b1 |-> (chan_mode == adc_format_pkg::MODE_INTERLEAVED)
      == $past(reg_wdata[`BIT_INTERLEAVE]))
      else $error("mode not stored");

   // bits that software cannot change keep their default pattern
   cfg_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cfg_write_s |-> (primary_configuration & ~`PRIMARY_CFG_WMASK)
      == (`PRIMARY_CFG_RESET & ~`PRIMARY_CFG_WMASK))
      else $error("fixed config bits disturbed");

   // time stamp output follows its input only while enabled
   stamp_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !timestamp_enable_bit |=> !timestamp_out)
      else $error("stamp while disabled");
   stamp_pass_a: assert property (@(posedge mclk) disable iff (!reset_n)
      timestamp_enable_bit && timestamp_in |=> timestamp_out)
      else $error("stamp lost while enabled");

   // offset fields and the reserved word follow the word written one cycle earlier
   sign_store_a: assert property (@(posedge mclk) disable iff (!reset_n)
      off_write_s |-> offset_sign == $past(reg_wdata[`BIT_OFFSET_SIGN]))
      else $error("offset sign not stored");
   magnitude_store_a: assert property (@(posedge mclk) disable iff (!reset_n)
      off_write_s |-> offset_magnitude == $past(reg_wdata[`OFFSET_MAG_MSB:0]))
      else $error("offset magnitude not stored");
   reserved_store_a: assert property (@(posedge mclk) disable iff (!reset_n)
      rsvd_write_s |-> reserved_fixed_pattern == $past(reg_wdata))
      else $error("reserved word not stored");

   // misuse of reserved contents is flagged and the flag stays until reset
   misuse_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_rsvd && reg_wdata != `RESERVED_FIXED_RESET |=> reserved_misuse)
      else $error("misuse not flagged");
   offset_misuse_a: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_off && (reg_wdata & `I_OFFSET_RSVD_MASK) != '0 |=> reserved_misuse)
      else $error("offset misuse not flagged");
   misuse_sticky_a: assert property (@(posedge mclk) disable iff (!reset_n)
      reserved_misuse |=> reserved_misuse)
      else $error("misuse flag dropped");
endmodule // adc_format_regs

/* include/adc_format_params.svh */
// register offsets, field positions, reset values and widths of the format/offset bank
`ifndef ADC_FORMAT_PARAMS_SVH
`define ADC_FORMAT_PARAMS_SVH
`define ADDR_W 4
`define DATA_W 16
`define SAMPLE_W 12
`define OFFSET_W 13
`define REG_PRIMARY_CFG 4'h0
`define REG_RESERVED_FIXED 4'h1
`define REG_I_OFFSET 4'h2
`define PRIMARY_CFG_RESET 16'h2000
`define RESERVED_FIXED_RESET 16'h2907
`define I_OFFSET_RESET 16'h0000
`define BIT_INTERLEAVE 7
`define BIT_TWOS_COMP 4
`define BIT_TIMESTAMP 3
`define BIT_SINGLE_RATE 2
`define BIT_OFFSET_SIGN 12
`define OFFSET_MAG_MSB 11
`define I_OFFSET_RSVD_MASK 16'hE000
`define PRIMARY_CFG_WMASK 16'hFDFC
`define SAMPLE_MAX 13'h0FFF
`define SAMPLE_MID 12'h800
`endif

/* include/adc_format_pkg.sv */
// types shared by the format/offset register bank
package adc_format_pkg;
   typedef enum logic [1:0] {
      MODE_DUAL = 2'b00,
      MODE_INTERLEAVED = 2'b01
   } chan_mode_e;
   typedef logic [15:0] reg_word_t;
endpackage

/* hdl/offset_apply.sv */
// signed offset apply and output number format for one sample
`timescale 1ns/10ps
`include "adc_format_params.svh"
module offset_apply (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [`SAMPLE_W-1:0] sample_in,
   input wire logic offset_sign,
   input wire logic [`SAMPLE_W-1:0] offset_magnitude,
   input wire logic twos_comp_select,
   output logic [`SAMPLE_W-1:0] sample_out
);
   // widened sum so saturation can be detected before cutting back
   wire logic [`OFFSET_W-1:0] wide_in = {1'b0, sample_in};
   wire logic [`OFFSET_W-1:0] wide_mag = {1'b0, offset_magnitude};
   wire logic underflow = offset_sign && (wide_mag > wide_in);
   wire logic [`OFFSET_W-1:0] sum = offset_sign ? wide_in - wide_mag : wide_in + wide_mag;
   // full scale kept at the wide width so it is cut back on purpose
   wire logic [`OFFSET_W-1:0] wide_max = `SAMPLE_MAX;
   wire logic overflow = !offset_sign && (sum > wide_max);
   wire logic [`SAMPLE_W-1:0] clipped = underflow ? '0 :
      overflow ? wide_max[`SAMPLE_W-1:0] : sum[`SAMPLE_W-1:0];
   // two's complement is offset binary with the top bit flipped
   wire logic [`SAMPLE_W-1:0] formatted = twos_comp_select ? (clipped ^ `SAMPLE_MID) : clipped;

   // registered so the data output is glitch free
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sample_out <= '0;
      end else begin
         sample_out <= formatted;
      end
   end
endmodule // offset_apply

/* tb/adc_format_regs_tb_top.sv */
// self-checking bench for the format and offset register bank
`timescale 1ns/10ps
`include "adc_format_params.svh"
module adc_format_regs_tb_top;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic [`ADDR_W-1:0] reg_addr = '0;
   logic [`DATA_W-1:0] reg_wdata = '0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [`DATA_W-1:0] reg_rdata;
   logic [`SAMPLE_W-1:0] sample_in = '0;
   logic timestamp_in = 1'b0;
   logic [`SAMPLE_W-1:0] sample_out;
   logic timestamp_out, single_rate_select, interleave_enable, reserved_misuse;
   adc_format_pkg::chan_mode_e chan_mode;
   int err_total = 0;
   int cmp_count = 0;
   // 20 MHz clock
   always #25 mclk = ~mclk;
   adc_format_regs dut_u (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .sample_in(sample_in), .timestamp_in(timestamp_in), .sample_out(sample_out),
      .timestamp_out(timestamp_out), .single_rate_select(single_rate_select),
      .interleave_enable(interleave_enable), .chan_mode(chan_mode),
      .reserved_misuse(reserved_misuse));
   // case equality so an unknown never matches
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_write <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   // extra cycles let a fresh register write reach the output stage
   task automatic smp(input logic [11:0] s, input logic [11:0] exp);
      @(posedge mclk);
      sample_in <= s;
      repeat (3) @(posedge mclk);
      #1 chk({4'h0, sample_out}, {4'h0, exp});
   endtask
   task automatic final_report;
      if (err_total == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // watchdog, far beyond the roughly one hundred cycles the tests need
   initial begin
      #(3000 * 50);
      err_total++;
      final_report;
   end
   // main sequence
   initial begin
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      rd_chk(`REG_PRIMARY_CFG, `PRIMARY_CFG_RESET);
      rd_chk(`REG_RESERVED_FIXED, `RESERVED_FIXED_RESET);
      rd_chk(`REG_I_OFFSET, `I_OFFSET_RESET);
      rd_chk(4'h5, 16'h0000);
      smp(12'h800, 12'h800);
      wr(`REG_PRIMARY_CFG, 16'hFFFF);
      rd_chk(`REG_PRIMARY_CFG, 16'hFDFC);
      wr(`REG_PRIMARY_CFG, 16'h208C);
      wr(4'h5, 16'hFFFF);
      rd_chk(`REG_PRIMARY_CFG, 16'h208C);
      chk({12'h0, single_rate_select, interleave_enable, chan_mode}, 16'h000D);
      @(posedge mclk);
      timestamp_in <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 chk({15'h0, timestamp_out}, 16'h0001);
      wr(`REG_PRIMARY_CFG, 16'h2010);
      repeat (2) @(posedge mclk);
      #1 chk({13'h0, timestamp_out, single_rate_select, interleave_enable}, 16'h0000);
      wr(`REG_I_OFFSET, 16'h1005);
      smp(12'h800, 12'hFFB);
      wr(`REG_PRIMARY_CFG, 16'h2000);
      smp(12'h800, 12'h7FB);
      wr(`REG_I_OFFSET, 16'h0005);
      smp(12'h800, 12'h805);
      wr(`REG_I_OFFSET, 16'h0FFF);
      smp(12'h000, 12'hFFF);
      smp(12'h001, 12'hFFF);
      wr(`REG_I_OFFSET, 16'h1FFF);
      smp(12'hFFF, 12'h000);
      wr(`REG_I_OFFSET, 16'h0800);
      smp(12'h100, 12'h900);
      wr(`REG_I_OFFSET, 16'h1800);
      smp(12'hFFF, 12'h7FF);
      smp(12'h7FF, 12'h000);
      wr(`REG_RESERVED_FIXED, 16'h2907);
      #1 chk({15'h0, reserved_misuse}, 16'h0000);
      wr(`REG_I_OFFSET, 16'h2000);
      repeat (2) @(posedge mclk);
      #1 chk({15'h0, reserved_misuse}, 16'h0001);
      // second reset in mid-run restores every default and clears the sticky flag
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      #1 chk({15'h0, reserved_misuse}, 16'h0000);
      rd_chk(`REG_I_OFFSET, `I_OFFSET_RESET);
      rd_chk(`REG_RESERVED_FIXED, `RESERVED_FIXED_RESET);
      rd_chk(`REG_PRIMARY_CFG, `PRIMARY_CFG_RESET);
      chk({12'h0, single_rate_select, interleave_enable, chan_mode}, 16'h0000);
      // a foreign pattern in the reserved word is kept but flagged
      wr(`REG_RESERVED_FIXED, 16'h2906);
      #1 chk({15'h0, reserved_misuse}, 16'h0001);
      rd_chk(`REG_RESERVED_FIXED, 16'h2906);
      final_report;
   end
endmodule // adc_format_regs_tb_top
